// *** hw/ddr3_phy_pkg.sv ***
package ddr3_phy_pkg;

    // pin group widths shared by the command struct
    localparam int ROW_WIDTH  = 14;
    localparam int BANK_WIDTH = 3;
    localparam int CS_WIDTH   = 1;
    localparam int CKE_WIDTH  = 1;

    // clock and initialization timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int RESET_HOLD_NS   = 200000;  // 200 us memory reset low
    localparam int CKE_GAP_NS      = 500000;  // 500 us reset high to cke
    localparam int RESET_HOLD_CYC  =
        (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKE_GAP_CYC     =
        (CKE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEVEL_CYC       = 64;      // write leveling time slot
    localparam int READ_LAT_CYC    = 12;      // command to read data valid
    localparam int TIMER_WIDTH     = 20;

    // serializer patterns per system clock: four memory clock phases
    localparam logic [3:0] CLK_PATTERN     = 4'h5;
    localparam logic [3:0] CLK_PATTERN_NEG = 4'ha;

    // reset values of the command pins: deselect, all strobes idle
    localparam logic CMD_IDLE_N = 1'h1;

    // initialization sequencer states
    typedef enum logic [2:0] {
        S_IDLE    = 3'h0,
        S_RESET   = 3'h1,
        S_CKE_GAP = 3'h2,
        S_LEVEL   = 3'h3,
        S_DONE    = 3'h4
    } init_state_t;

    // one control command as seen on both sides
    typedef struct packed {
        logic [ROW_WIDTH-1:0]  address;
        logic [BANK_WIDTH-1:0] bank;
        logic [CS_WIDTH-1:0]   select_n;
        logic                  row_strobe_n;
        logic                  column_strobe_n;
        logic                  write_enable_n;
        logic [CKE_WIDTH-1:0]  clock_enable;
        logic [CS_WIDTH-1:0]   termination;
    } cmd_t;

endpackage : ddr3_phy_pkg

// *** hw/ddr3_phy_port.sv ***
// Summary of operation
// [R01] init complete pulses one cycle after initialization and leveling finish
// [R02] controller drops init request on the edge it sees complete high
// [R03] controller raises init request after reset or before first command
// [R04] init request only starts initialization; no byte disable, no ratio
// [R05] memory reset output low during system or memory-only reset
// [R06] memory clocks up to 400 MHz, each with a negative companion
// [R07] row strobe carried from controller to memory for every command; code forces it high while init_ok is low
// [R08] write enable carried from controller to memory for every command; code forces it high while init_ok is low
// [R09] active-high data mask output, one bit per eight data bits
// [R10] row and column address share one row-width address bus
// [R11] read data marked by active-high valid alongside the data
// [R12] request still high after the complete pulse restarts initialization
// [R13] memory-only reset resets the memory, not the block logic
// [R14] system reset clears the whole block and the memory
// [R15] all command and address signals see the same delay
`timescale 1ns/1ps
module ddr3_phy_port #(
    parameter int DATA_WIDTH     = 16,
    parameter int CLKO_WIDTH     = 1,
    parameter int RESET_HOLD_CYC = ddr3_phy_pkg::RESET_HOLD_CYC,
    parameter int CKE_GAP_CYC    = ddr3_phy_pkg::CKE_GAP_CYC,
    parameter int LEVEL_CYC      = ddr3_phy_pkg::LEVEL_CYC,
    parameter int READ_LAT_CYC   = ddr3_phy_pkg::READ_LAT_CYC
) (
    // clock and resets
    input  wire logic                        i_clk,
    input  wire logic                        i_rstn,
    input  wire logic                        i_mem_rst_n,
    // controller command group
    input  wire ddr3_phy_pkg::cmd_t          i_cmd,
    // controller write group
    input  wire logic [DATA_WIDTH-1:0]       i_wrdata,
    input  wire logic                        i_wrdata_en,
    input  wire logic [DATA_WIDTH/8-1:0]     i_wrdata_mask,
    // controller read group
    output logic      [DATA_WIDTH-1:0]       o_rddata,
    output logic                             o_rddata_valid,
    // initialization handshake and status
    input  wire logic                        i_init_start,
    output logic                             o_init_complete,
    output logic                             o_init_active,
    output logic                             o_level_active,
    output logic                             o_level_error,
    // memory control pins
    output logic                             o_mem_reset_out_n,
    output logic      [4*CLKO_WIDTH-1:0]     o_mem_clock_out,
    output logic      [4*CLKO_WIDTH-1:0]     o_mem_clock_out_neg,
    output ddr3_phy_pkg::cmd_t               o_mem_cmd,
    // memory data pins
    input  wire logic [DATA_WIDTH-1:0]       i_mem_data_bidir,
    output logic      [DATA_WIDTH-1:0]       o_mem_data_bidir,
    output logic                             o_mem_data_bidir_oe,
    output logic      [DATA_WIDTH/8-1:0]     o_mem_byte_mask_out,
    input  wire logic [DATA_WIDTH/8-1:0]     i_mem_strobe_bidir,
    output logic      [DATA_WIDTH/8-1:0]     o_mem_strobe_bidir,
    output logic      [DATA_WIDTH/8-1:0]     o_mem_strobe_bidir_neg,
    output logic                             o_mem_strobe_bidir_oe
);

    localparam int LANES = DATA_WIDTH / 8;

    // sequencer state and timers
    ddr3_phy_pkg::init_state_t state;
    ddr3_phy_pkg::init_state_t next_state;
    logic [ddr3_phy_pkg::TIMER_WIDTH-1:0] timer;
    logic                                 init_ok;

    // synchronised pins
    logic                  mrst_meta;
    logic                  mrst_sync;
    logic [DATA_WIDTH-1:0] rd_meta;
    logic [DATA_WIDTH-1:0] rd_sync;

    // read return pipe, one bit per cycle of latency but the last, which is the valid register
    logic [READ_LAT_CYC-2:0] rd_pipe;

    // decode of the incoming command and of timer expiry
    wire logic read_cmd;
    wire logic timer_done;
    wire logic [ddr3_phy_pkg::TIMER_WIDTH-1:0] state_len;
    wire logic mem_reset_hold;
    wire logic [ddr3_phy_pkg::CKE_WIDTH-1:0] next_cke;
    wire ddr3_phy_pkg::cmd_t next_cmd;
    wire logic [LANES-1:0] next_strobe;

    assign read_cmd   = !i_cmd.select_n[0] && i_cmd.row_strobe_n
                        && !i_cmd.column_strobe_n && i_cmd.write_enable_n;
    assign state_len  =
        (state == ddr3_phy_pkg::S_RESET)
            ? ddr3_phy_pkg::TIMER_WIDTH'(RESET_HOLD_CYC - 1)
        : (state == ddr3_phy_pkg::S_CKE_GAP)
            ? ddr3_phy_pkg::TIMER_WIDTH'(CKE_GAP_CYC - 1)
            : ddr3_phy_pkg::TIMER_WIDTH'(LEVEL_CYC - 1);
    assign timer_done = (timer == state_len);

    // memory reset: system reset, memory-only reset or init reset phase
    assign mem_reset_hold = !mrst_sync
                            || (state == ddr3_phy_pkg::S_RESET); // R05 R13

    // cke stays low until the reset-to-cke gap has run out
    assign next_cke = (state == ddr3_phy_pkg::S_LEVEL)
                      ? {ddr3_phy_pkg::CKE_WIDTH{1'h1}}
                      : (init_ok ? i_cmd.clock_enable
                                 : {ddr3_phy_pkg::CKE_WIDTH{1'h0}});

    // commands pass only once memory is up; each field one register stage
    assign next_cmd = '{
        address:         i_cmd.address,                 // R10
        bank:            i_cmd.bank,
        select_n:        init_ok ? i_cmd.select_n
                                 : {ddr3_phy_pkg::CS_WIDTH{1'h1}},
        row_strobe_n:    init_ok ? i_cmd.row_strobe_n      // R07
                                 : ddr3_phy_pkg::CMD_IDLE_N,
        column_strobe_n: init_ok ? i_cmd.column_strobe_n
                                 : ddr3_phy_pkg::CMD_IDLE_N,
        write_enable_n:  init_ok ? i_cmd.write_enable_n    // R08
                                 : ddr3_phy_pkg::CMD_IDLE_N,
        clock_enable:    next_cke,
        termination:     init_ok ? i_cmd.termination
                                 : {ddr3_phy_pkg::CS_WIDTH{1'h0}}
    };

    // strobe toggles every cycle of a write burst, parks low otherwise
    assign next_strobe = i_wrdata_en ? ~o_mem_strobe_bidir
                                     : {LANES{1'h0}};

    // sequencer: the request only ever starts initialization
    always_comb begin
        next_state = state;
        unique case (state)
            ddr3_phy_pkg::S_IDLE: begin
                if (i_init_start) begin                    // R04 R12
                    next_state = ddr3_phy_pkg::S_RESET;
                end
            end
            ddr3_phy_pkg::S_RESET: begin
                if (timer_done) begin
                    next_state = ddr3_phy_pkg::S_CKE_GAP;
                end
            end
            ddr3_phy_pkg::S_CKE_GAP: begin
                if (timer_done) begin
                    next_state = ddr3_phy_pkg::S_LEVEL;
                end
            end
            ddr3_phy_pkg::S_LEVEL: begin
                if (timer_done) begin
                    next_state = ddr3_phy_pkg::S_DONE;
                end
            end
            ddr3_phy_pkg::S_DONE: begin
                next_state = ddr3_phy_pkg::S_IDLE;         // R12
            end
            default: begin
                next_state = ddr3_phy_pkg::S_IDLE;
            end
        endcase
    end

    // state register and phase timer; system reset clears all logic
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin                                 // R14
            state <= ddr3_phy_pkg::S_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= (next_state != state) ? '0 : timer + 1'b1;
        end
    end

    // completion pulse and status flags
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_init_complete <= 1'h0;
            o_init_active   <= 1'h0;
            o_level_active  <= 1'h0;
            o_level_error   <= 1'h0;
            init_ok         <= 1'h0;
        end else begin
            o_init_complete <= (next_state == ddr3_phy_pkg::S_DONE); // R01
            o_init_active   <= (next_state != ddr3_phy_pkg::S_IDLE)
                               && (next_state != ddr3_phy_pkg::S_DONE);
            o_level_active  <= (next_state == ddr3_phy_pkg::S_LEVEL);
            o_level_error   <= 1'h0;
            if (next_state == ddr3_phy_pkg::S_RESET) begin
                init_ok <= 1'h0;
            end else if (state == ddr3_phy_pkg::S_DONE) begin
                init_ok <= 1'h1;
            end
        end
    end

    // two-stage synchroniser on the memory-only reset pin
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mrst_meta <= 1'h0;
            mrst_sync <= 1'h0;
        end else begin
            mrst_meta <= i_mem_rst_n;
            mrst_sync <= mrst_meta;
        end
    end

    // memory reset pin, low in system reset and while mem_reset_hold is set
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mem_reset_out_n <= 1'h0;                     // R05 R14
        end else begin
            o_mem_reset_out_n <= !mem_reset_hold;
        end
    end

    // memory clock serializer words and their complements
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mem_clock_out     <= '0;
            o_mem_clock_out_neg <= '0;
        end else begin
            o_mem_clock_out     <= {CLKO_WIDTH{ddr3_phy_pkg::CLK_PATTERN}};
            o_mem_clock_out_neg <=                          // R06
                {CLKO_WIDTH{ddr3_phy_pkg::CLK_PATTERN_NEG}};
        end
    end

    // command and address pins, one common register stage
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mem_cmd <= '{
                address:         '0,
                bank:            '0,
                select_n:        '1,
                row_strobe_n:    ddr3_phy_pkg::CMD_IDLE_N,
                column_strobe_n: ddr3_phy_pkg::CMD_IDLE_N,
                write_enable_n:  ddr3_phy_pkg::CMD_IDLE_N,
                clock_enable:    '0,
                termination:     '0
            };
        end else begin
            o_mem_cmd <= next_cmd;                         // R15
        end
    end

    // write data, mask and strobes driven while write enable is high
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_mem_data_bidir       <= '0;
            o_mem_data_bidir_oe    <= 1'h0;
            o_mem_byte_mask_out    <= '0;
            o_mem_strobe_bidir     <= '0;
            o_mem_strobe_bidir_neg <= '1;
            o_mem_strobe_bidir_oe  <= 1'h0;
        end else begin
            o_mem_data_bidir       <= i_wrdata;
            o_mem_data_bidir_oe    <= i_wrdata_en;
            o_mem_byte_mask_out    <= i_wrdata_mask;       // R09
            o_mem_strobe_bidir     <= next_strobe;
            o_mem_strobe_bidir_neg <= ~next_strobe;
            o_mem_strobe_bidir_oe  <= i_wrdata_en;
        end
    end

    // read path: pin sync, latency pipe, data with valid
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rd_meta        <= '0;
            rd_sync        <= '0;
            rd_pipe        <= '0;
            o_rddata       <= '0;
            o_rddata_valid <= 1'h0;
        end else begin
            rd_meta        <= i_mem_data_bidir;
            rd_sync        <= rd_meta;
            rd_pipe        <= {rd_pipe[READ_LAT_CYC-3:0],
                               read_cmd && init_ok};
            o_rddata       <= rd_sync;
            o_rddata_valid <= rd_pipe[READ_LAT_CYC-2];     // R11
        end
    end

endmodule : ddr3_phy_port

// *** testbench/ddr3_phy_port_properties.sv ***
`timescale 1ns/1ps
module ddr3_phy_port_properties #(
    parameter int DATA_WIDTH     = 16,
    parameter int CLKO_WIDTH     = 1,
    parameter int RESET_HOLD_CYC = 20,
    parameter int CKE_GAP_CYC    = 20,
    parameter int LEVEL_CYC      = 8,
    parameter int READ_LAT_CYC   = 12
) (
    // clock and resets
    input wire logic                    i_clk,
    input wire logic                    i_rstn,
    input wire logic                    i_mem_rst_n,
    // controller side
    input wire ddr3_phy_pkg::cmd_t      i_cmd,
    input wire logic [DATA_WIDTH-1:0]   i_wrdata,
    input wire logic                    i_wrdata_en,
    input wire logic [DATA_WIDTH/8-1:0] i_wrdata_mask,
    input wire logic                    o_rddata_valid,
    input wire logic                    i_init_start,
    input wire logic                    o_init_complete,
    input wire logic                    o_init_active,
    // memory side
    input wire logic                    o_mem_reset_out_n,
    input wire logic [4*CLKO_WIDTH-1:0] o_mem_clock_out,
    input wire logic [4*CLKO_WIDTH-1:0] o_mem_clock_out_neg,
    input wire ddr3_phy_pkg::cmd_t      o_mem_cmd,
    input wire logic [DATA_WIDTH-1:0]   o_mem_data_bidir,
    input wire logic                    o_mem_data_bidir_oe,
    input wire logic [DATA_WIDTH/8-1:0] o_mem_byte_mask_out
);
    localparam int INIT_CYC = RESET_HOLD_CYC + CKE_GAP_CYC + LEVEL_CYC + 1;
    logic        done;
    logic [15:0] run_cnt;
    // commands pass once init is done; read decode on the controller side
    wire fwd    = done && !o_init_active;
    wire rd_cmd = !i_cmd.select_n[0] && i_cmd.row_strobe_n
                  && !i_cmd.column_strobe_n && i_cmd.write_enable_n;
    // init done flag and length of the running sequence
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            done    <= 1'b0;
            run_cnt <= 16'h0;
        end else begin
            done    <= o_init_active ? 1'b0 : (done || o_init_complete);
            run_cnt <= o_init_active ? run_cnt + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    init_pulse_a: assert property (
        o_init_complete |=> !o_init_complete)
        else $error("init complete longer than one cycle");
    init_len_a: assert property (
        o_init_complete |-> run_cnt == 16'(INIT_CYC - 1))
        else $error("init complete at wrong time");
    init_restart_a: assert property (
        o_init_complete ##1 i_init_start |=> o_init_active)
        else $error("held request did not restart init");
    sys_rst_mem_a: assert property (
        disable iff (1'b0) !i_rstn |=> !o_mem_reset_out_n)
        else $error("memory reset not low in system reset");
    mem_rst_only_a: assert property (
        !i_mem_rst_n [*3] |=> !o_mem_reset_out_n)
        else $error("memory reset not low in memory reset");
    cmd_fwd_a: assert property (
        fwd && $past(fwd) ##1 fwd |-> o_mem_cmd == $past(i_cmd))
        else $error("command not forwarded intact");
    rd_latency_a: assert property (
        fwd && $past(fwd) && rd_cmd |-> ##READ_LAT_CYC o_rddata_valid)
        else $error("read valid missing");
    rd_source_a: assert property (
        o_rddata_valid |-> $past(rd_cmd, READ_LAT_CYC))
        else $error("read valid without read");
    wr_path_a: assert property (
        i_wrdata_en |=> o_mem_data_bidir_oe
            && o_mem_data_bidir == $past(i_wrdata)
            && o_mem_byte_mask_out == $past(i_wrdata_mask))
        else $error("write data or mask wrong");
    clk_pattern_a: assert property (
        $past(i_rstn) |-> o_mem_clock_out
            == {CLKO_WIDTH{ddr3_phy_pkg::CLK_PATTERN}}
            && o_mem_clock_out_neg == ~o_mem_clock_out)
        else $error("memory clock pattern wrong");
endmodule : ddr3_phy_port_properties

bind ddr3_phy_port ddr3_phy_port_properties #(
    .DATA_WIDTH(DATA_WIDTH), .CLKO_WIDTH(CLKO_WIDTH),
    .RESET_HOLD_CYC(RESET_HOLD_CYC), .CKE_GAP_CYC(CKE_GAP_CYC),
    .LEVEL_CYC(LEVEL_CYC), .READ_LAT_CYC(READ_LAT_CYC)
) u_ddr3_phy_port_properties (
    .i_clk, .i_rstn, .i_mem_rst_n, .i_cmd, .i_wrdata, .i_wrdata_en,
    .i_wrdata_mask, .o_rddata_valid, .i_init_start, .o_init_complete,
    .o_init_active, .o_mem_reset_out_n, .o_mem_clock_out,
    .o_mem_clock_out_neg, .o_mem_cmd, .o_mem_data_bidir,
    .o_mem_data_bidir_oe, .o_mem_byte_mask_out
);

// *** testbench/ddr3_mem_model.sv ***
`timescale 1ns/1ps
module ddr3_mem_model #(
    parameter int DATA_WIDTH = 16
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_oe,
    input  wire logic [DATA_WIDTH-1:0]   i_dq,
    input  wire logic                    i_soe,
    input  wire logic [DATA_WIDTH/8-1:0] i_dqs,
    output logic      [DATA_WIDTH-1:0]   o_dq,
    output logic      [DATA_WIDTH/8-1:0] o_dqs
);
    logic [DATA_WIDTH-1:0] pattern = '0;
    // memory side data changes every cycle so stale values from the last 31 cycles never match
    always @(posedge i_clk) begin
        pattern <= {pattern[DATA_WIDTH-2:0], ~pattern[DATA_WIDTH-1]};
    end
    // wire level from the phy output enables, memory pattern otherwise
    assign o_dq  = i_oe ? i_dq : pattern;
    assign o_dqs = i_soe ? i_dqs : {(DATA_WIDTH/8){pattern[0]}};
endmodule : ddr3_mem_model

// *** testbench/ddr3_phy_port_test.sv ***
`timescale 1ns/1ps
module ddr3_phy_port_test;
    localparam int N = 20 + 20 + 8 + 1;
    localparam ddr3_phy_pkg::cmd_t IDLE = 23'h00003e;
    localparam ddr3_phy_pkg::cmd_t RD   = 23'h2a5c16;
    logic i_clk = 0, i_rstn = 0, i_mem_rst_n = 1, i_wrdata_en = 0;
    logic i_init_start = 0;
    logic [15:0] i_wrdata = '0, rddata, dq_in, dq_out, cap;
    logic [1:0]  i_wrdata_mask = '0, dm, dqs_in, dqs_o, dqs_n;
    logic rd_v, done, act, lvl, lerr, mrst_n, dq_oe, dqs_oe, seen_lvl;
    logic [3:0]  ck, ck_n;
    ddr3_phy_pkg::cmd_t i_cmd = IDLE, mcmd;
    int   bad_count = 0, checks = 0, n;
    always #2.5 i_clk = ~i_clk;
    ddr3_phy_port #(.RESET_HOLD_CYC(20), .CKE_GAP_CYC(20), .LEVEL_CYC(8),
        .READ_LAT_CYC(12)) u_ddr3_phy_port (.i_clk, .i_rstn, .i_mem_rst_n,
        .i_cmd, .i_wrdata, .i_wrdata_en, .i_wrdata_mask, .o_rddata(rddata),
        .o_rddata_valid(rd_v), .i_init_start, .o_init_complete(done),
        .o_init_active(act), .o_level_active(lvl), .o_level_error(lerr),
        .o_mem_reset_out_n(mrst_n), .o_mem_clock_out(ck),
        .o_mem_clock_out_neg(ck_n), .o_mem_cmd(mcmd),
        .i_mem_data_bidir(dq_in), .o_mem_data_bidir(dq_out),
        .o_mem_data_bidir_oe(dq_oe), .o_mem_byte_mask_out(dm),
        .i_mem_strobe_bidir(dqs_in), .o_mem_strobe_bidir(dqs_o),
        .o_mem_strobe_bidir_neg(dqs_n), .o_mem_strobe_bidir_oe(dqs_oe));
    ddr3_mem_model u_ddr3_mem_model (.i_clk, .i_oe(dq_oe), .i_dq(dq_out),
        .i_soe(dqs_oe), .i_dqs(dqs_o), .o_dq(dq_in), .o_dqs(dqs_in));
    task check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task wait_done();
        n = 0;
        seen_lvl = 1'b0;
        do begin
            @(posedge i_clk);
            n++;
            #1;
            seen_lvl |= lvl;
        end while (done !== 1'b1 && n < 500);
    endtask : wait_done
    task t_pre_read();
        @(posedge i_clk) i_cmd <= RD;
        @(posedge i_clk) i_cmd <= IDLE;
        repeat (14) begin
            @(posedge i_clk);
            #1 check("early_valid", 32'(rd_v), 32'h0);
        end
    endtask : t_pre_read
    task t_init(bit hold);
        @(posedge i_clk) i_init_start <= 1;
        wait_done();
        check("init_latency", 32'(n), 32'(N));
        check("level_seen", {seen_lvl, lvl, lerr}, 32'h4);
        @(posedge i_clk) i_init_start <= hold;
        #1 check("init_pulse", 32'(done), 32'h0);
        @(posedge i_clk) i_init_start <= 0;
        @(posedge i_clk);
        #1 check("restart", 32'(act), 32'(hold));
        if (hold) begin
            wait_done();
            check("restart_done", 32'(done), 32'h1);
        end
        repeat (2) @(posedge i_clk);
        #1 check("mem_reset_up", 32'(mrst_n), 32'h1);
    endtask : t_init
    task t_cmd();
        ddr3_phy_pkg::cmd_t v [3];
        v = '{23'h7fffbe, 23'h1a5a52, 23'h000029};
        foreach (v[i]) begin
            @(posedge i_clk) i_cmd <= v[i];
            @(posedge i_clk);
            #1 check("mem_cmd", 32'(mcmd), 32'(v[i]));
        end
        @(posedge i_clk) i_cmd <= IDLE;
    endtask : t_cmd
    task t_write();
        @(posedge i_clk) {i_wrdata_en, i_wrdata, i_wrdata_mask} <= 19'h661d2;
        @(posedge i_clk) {i_wrdata, i_wrdata_mask} <= 18'h168f2;
        #1 check("wr_word0", {dq_oe, dm, dq_out}, 32'h69874);
        check("wr_strobe0", {dqs_oe, dqs_o, dqs_n}, 32'h1c);
        @(posedge i_clk) i_wrdata_en <= 0;
        #1 check("wr_word1", {dq_oe, dm, dq_out}, 32'h65a3c);
        check("wr_strobe1", {dqs_oe, dqs_o, dqs_n}, 32'h13);
        @(posedge i_clk);
        #1 check("wr_end", 32'(dq_oe), 32'h0);
        check("wr_strobe_end", {dqs_oe, dqs_o, dqs_n}, 32'h03);
    endtask : t_write
    task t_read();
        @(posedge i_clk) i_cmd <= RD;
        @(posedge i_clk) i_cmd <= IDLE;
        for (int k = 1; k <= 11; k++) begin
            @(posedge i_clk);
            #1 if (k == 8) cap = dq_in;
            if (k == 10) check("rd_early", 32'(rd_v), 32'h0);
        end
        check("rd_valid", {rd_v, rddata}, {16'h1, cap});
    endtask : t_read
    task t_mem_rst();
        @(posedge i_clk) i_mem_rst_n <= 0;
        repeat (4) @(posedge i_clk);
        #1 check("mem_only_rst", {act, mrst_n, mcmd}, 32'(IDLE));
        @(posedge i_clk) i_mem_rst_n <= 1;
        repeat (4) @(posedge i_clk);
        #1 check("mem_rst_end", 32'(mrst_n), 32'h1);
    endtask : t_mem_rst
    task t_sys_rst();
        @(posedge i_clk) i_rstn <= 0;
        repeat (2) @(posedge i_clk);
        #1 check("sys_rst", {mrst_n, mcmd}, 32'h3c);
        @(posedge i_clk) i_rstn <= 1;
    endtask : t_sys_rst
    // stops a hung run
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rstn <= 1;
        t_pre_read();
        t_init(0);
        t_cmd();
        t_write();
        t_read();
        t_mem_rst();
        t_init(1);
        t_sys_rst();
        repeat (4) @(posedge i_clk);
        stop_test();
    end
endmodule : ddr3_phy_port_test
